// ---- cmi2c_bfm.sv ----
`default_nettype none
// ==========
// bus master model, open drain
module cmi2c_bfm (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 520;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    #Q sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
  endtask
  task automatic stop();
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask
  task automatic bit_xfer(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(last, r);
  endtask
endmodule
`default_nettype wire

// ---- cmi2c_defs.svh ----
`ifndef CMI2C_DEFS_SVH
`define CMI2C_DEFS_SVH
`define CMI2C_SLAVE_ADDR 7'h5D
`define CMI2C_NUM_REGS 10
`define CMI2C_REG_STATUS 4'h7
`define CMI2C_REG_FLAG 4'h9
`define CMI2C_CLK_HZ 25000000
`define CMI2C_TOUT_MS 32
`define CMI2C_TOUT_CYC ((`CMI2C_CLK_HZ / 1000) * `CMI2C_TOUT_MS)
`define CMI2C_RST_00 8'h80
`define CMI2C_RST_01 8'h00
`define CMI2C_RST_02 8'h00
`define CMI2C_RST_03 8'h81
`define CMI2C_RST_04 8'h01
`define CMI2C_RST_05 8'h03
`define CMI2C_RST_06 8'h92
`define CMI2C_RST_07 8'h00
`define CMI2C_RST_08 8'h00
`define CMI2C_RST_09 8'h00
`endif

// ---- cmi2c_pkg.sv ----
`default_nettype none
package cmi2c_pkg;
  typedef enum logic [2:0] {
    CMI2C_IDLE = 3'b000,
    CMI2C_RX = 3'b001,
    CMI2C_ACK = 3'b010,
    CMI2C_TX = 3'b011,
    CMI2C_RACK = 3'b100
  } cmi2c_state_t;

  typedef enum logic [1:0] {
    CMI2C_B_ADDR = 2'b00,
    CMI2C_B_REG = 2'b01,
    CMI2C_B_DATA = 2'b10
  } cmi2c_byte_t;

  // pin samples handed from the sampler to the link logic
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_fall;
    logic scl_rise;
    logic start;
    logic stop;
  } cmi2c_line_t;

  // one register write crossing into the core domain
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } cmi2c_wr_t;
endpackage
`default_nettype wire

// ---- cmi2c_slave.sv ----
`default_nettype none
`include "cmi2c_defs.svh"
module cmi2c_slave #(
  parameter int unsigned TOUT_CYC = `CMI2C_TOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic link_rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic [7:0] status_i,
  input wire logic [7:0] flag_i,
  output logic [7:0] reg_ctrl_o,
  output logic [7:0] reg_bal_o,
  output logic [7:0] reg_cur_o,
  output logic [7:0] reg_sc1_o,
  output logic [7:0] reg_sc2_o,
  output logic [7:0] reg_scc_o,
  output logic [7:0] reg_ot_o,
  output logic [7:0] reg_mask_o,
  output logic busy_o,
  output logic timeout_o
);
  // ==========================================
  // link domain state
  typedef struct packed {
    cmi2c_pkg::cmi2c_state_t st;
    cmi2c_pkg::cmi2c_byte_t kind;
    logic [7:0] sh;
    logic [3:0] bits;
    logic [3:0] ptr;
    logic rd;
    logic sda_oe;
    logic busy;
    logic [31:0] tcnt;
    logic tout;
    cmi2c_pkg::cmi2c_wr_t wr;
    logic wr_tgl;
  } cmi2c_link_st_t;

  cmi2c_pkg::cmi2c_line_t line;
  cmi2c_link_st_t l_q;
  cmi2c_link_st_t l_d;
  logic [7:0] regs_q [`CMI2C_NUM_REGS];
  logic [7:0] rd_byte;

  cmi2c_sync u_sync (
    .clk_i(link_clk_i),
    .rst_n_i(link_rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line_o(line)
  );

  function automatic logic [3:0] cmi2c_next(input logic [3:0] p);
    cmi2c_next = (p == 4'h9) ? 4'h0 : p + 4'h1;
  endfunction

  // ==========================================
  // read path: register bank sampled through two stages, stable per byte
  logic [7:0] rd_m_q;
  logic [7:0] rd_s_q;
  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      rd_m_q <= 8'h00;
      rd_s_q <= 8'h00;
    end else begin
      rd_m_q <= (l_q.ptr < 4'hA) ? regs_q[l_q.ptr] : 8'h00;
      rd_s_q <= rd_m_q;
    end
  end
  assign rd_byte = rd_s_q;

  // ==========================================
  // protocol engine
  always_comb begin
    l_d = l_q;
    if (line.scl_fall | line.start) begin
      l_d.tcnt = 32'h0;
    end else if (l_q.busy && l_q.tcnt < TOUT_CYC) begin
      l_d.tcnt = l_q.tcnt + 32'h1;
    end
    l_d.tout = 1'b0;
    if (line.start) begin
      l_d.st = cmi2c_pkg::CMI2C_RX;
      l_d.kind = cmi2c_pkg::CMI2C_B_ADDR;
      l_d.bits = 4'h0;
      l_d.sda_oe = 1'b0;
      l_d.busy = 1'b1;
    end else if (line.stop) begin
      l_d.st = cmi2c_pkg::CMI2C_IDLE;
      l_d.sda_oe = 1'b0;
      l_d.busy = 1'b0;
    end else if (l_q.busy && l_q.tcnt >= TOUT_CYC) begin
      l_d.st = cmi2c_pkg::CMI2C_IDLE;
      l_d.sda_oe = 1'b0;
      l_d.busy = 1'b0;
      l_d.tout = 1'b1;
    end else begin
      unique case (l_q.st)
        cmi2c_pkg::CMI2C_IDLE: begin
          l_d.sda_oe = 1'b0;
        end
        cmi2c_pkg::CMI2C_RX: begin
          if (line.scl_rise) begin
            l_d.sh = {l_q.sh[6:0], line.sda};
            l_d.bits = l_q.bits + 4'h1;
          end
          if (line.scl_fall && l_q.bits == 4'h8) begin
            l_d.bits = 4'h0;
            unique case (l_q.kind)
              cmi2c_pkg::CMI2C_B_ADDR: begin
                if (l_q.sh[7:1] == `CMI2C_SLAVE_ADDR) begin
                  l_d.rd = l_q.sh[0];
                  l_d.st = cmi2c_pkg::CMI2C_ACK;
                  l_d.sda_oe = 1'b1;
                end else begin
                  l_d.st = cmi2c_pkg::CMI2C_IDLE;
                end
              end
              cmi2c_pkg::CMI2C_B_REG: begin
                l_d.ptr = l_q.sh[3:0];
                l_d.st = cmi2c_pkg::CMI2C_ACK;
                l_d.sda_oe = 1'b1;
              end
              default: begin
                l_d.wr = '{addr: l_q.ptr, data: l_q.sh};
                l_d.wr_tgl = ~l_q.wr_tgl;
                l_d.st = cmi2c_pkg::CMI2C_ACK;
                l_d.sda_oe = 1'b1;
              end
            endcase
          end
        end
        cmi2c_pkg::CMI2C_ACK: begin
          if (line.scl_fall) begin
            if (l_q.kind == cmi2c_pkg::CMI2C_B_DATA) begin
              l_d.ptr = cmi2c_next(l_q.ptr);
            end
            if (l_q.kind == cmi2c_pkg::CMI2C_B_ADDR && l_q.rd) begin
              l_d.st = cmi2c_pkg::CMI2C_TX;
              l_d.kind = cmi2c_pkg::CMI2C_B_DATA;
              l_d.sh = rd_byte;
              l_d.sda_oe = ~rd_byte[7];
              l_d.bits = 4'h0;
            end else begin
              l_d.st = cmi2c_pkg::CMI2C_RX;
              l_d.kind = (l_q.kind == cmi2c_pkg::CMI2C_B_ADDR) ?
                cmi2c_pkg::CMI2C_B_REG : cmi2c_pkg::CMI2C_B_DATA;
              l_d.sda_oe = 1'b0;
            end
          end
        end
        cmi2c_pkg::CMI2C_TX: begin
          if (line.scl_fall) begin
            if (l_q.bits == 4'h7) begin
              l_d.st = cmi2c_pkg::CMI2C_RACK;
              l_d.sda_oe = 1'b0;
              l_d.ptr = cmi2c_next(l_q.ptr);
            end else begin
              l_d.sh = {l_q.sh[6:0], 1'b0};
              l_d.sda_oe = ~l_q.sh[6];
              l_d.bits = l_q.bits + 4'h1;
            end
          end
        end
        cmi2c_pkg::CMI2C_RACK: begin
          if (line.scl_rise) begin
            l_d.rd = ~line.sda;
          end
          if (line.scl_fall) begin
            if (l_q.rd) begin
              l_d.st = cmi2c_pkg::CMI2C_TX;
              l_d.sh = rd_byte;
              l_d.sda_oe = ~rd_byte[7];
              l_d.bits = 4'h0;
            end else begin
              l_d.st = cmi2c_pkg::CMI2C_IDLE;
            end
          end
        end
        default: begin
          l_d.st = cmi2c_pkg::CMI2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // ==========================================
  // core domain: write toggle crossing and register bank
  typedef struct packed {
    logic [2:0] tgl;
    logic [2:0] busy;
    logic [2:0] tout;
    logic tout_seen;
  } cmi2c_core_st_t;

  cmi2c_core_st_t c_q;
  cmi2c_core_st_t c_d;

  always_comb begin
    c_d = c_q;
    c_d.tgl = {c_q.tgl[1:0], l_q.wr_tgl};
    c_d.busy = {c_q.busy[1:0], l_q.busy};
    c_d.tout = {c_q.tout[1:0], l_q.tout};
    c_d.tout_seen = c_q.tout[1] & ~c_q.tout[2];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regs_q[0] <= `CMI2C_RST_00;
      regs_q[1] <= `CMI2C_RST_01;
      regs_q[2] <= `CMI2C_RST_02;
      regs_q[3] <= `CMI2C_RST_03;
      regs_q[4] <= `CMI2C_RST_04;
      regs_q[5] <= `CMI2C_RST_05;
      regs_q[6] <= `CMI2C_RST_06;
      regs_q[7] <= `CMI2C_RST_07;
      regs_q[8] <= `CMI2C_RST_08;
      regs_q[9] <= `CMI2C_RST_09;
    end else begin
      regs_q[7] <= status_i;
      regs_q[9] <= flag_i;
      if ((c_q.tgl[1] ^ c_q.tgl[2]) && l_q.wr.addr < 4'hA &&
          l_q.wr.addr != `CMI2C_REG_STATUS && l_q.wr.addr != `CMI2C_REG_FLAG) begin
        regs_q[l_q.wr.addr] <= l_q.wr.data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      busy_o <= c_q.busy[2];
      timeout_o <= c_q.tout_seen;
    end
  end

  assign reg_ctrl_o = regs_q[0];
  assign reg_bal_o = regs_q[1];
  assign reg_cur_o = regs_q[2];
  assign reg_sc1_o = regs_q[3];
  assign reg_sc2_o = regs_q[4];
  assign reg_scc_o = regs_q[5];
  assign reg_ot_o = regs_q[6];
  assign reg_mask_o = regs_q[8];
  assign sda_o = 1'b0;
  assign sda_oe_o = l_q.sda_oe;
  assign scl_o = 1'b0;
  assign scl_oe_o = 1'b0;
endmodule
`default_nettype wire

// ---- cmi2c_sva.sv ----
`default_nettype none
// ==========
// bus checker
module cmi2c_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic link_rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic scl_o,
  input wire logic sda_oe_o,
  input wire logic scl_oe_o,
  input wire logic [7:0] reg_ctrl_o,
  input wire logic [7:0] reg_mask_o,
  input wire logic busy_o,
  input wire logic timeout_o
);
  a_oe_scl_low: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i) $changed(sda_oe_o) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_drive_low_only: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i) !sda_o && !scl_o && !scl_oe_o)
    else $error("bus driven high or scl held");
  a_start_busy: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i)
    scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:8] busy_o)
    else $error("start not taken");
  a_stop_idle: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i)
    scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:8] !busy_o)
    else $error("stop not taken");
  a_tout_pulse: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) timeout_o |=> !timeout_o)
    else $error("timeout pulse too long");
  a_tout_release: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) timeout_o |-> ##[0:16] (!busy_o && !sda_oe_o))
    else $error("bus not released on timeout");
  a_ack_in_frame: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) $rose(sda_oe_o) |-> busy_o)
    else $error("sda driven outside a transfer");
  a_regs_quiet: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) !busy_o |=> $stable({reg_ctrl_o, reg_mask_o}))
    else $error("register changed while idle");
endmodule
bind cmi2c_slave cmi2c_sva u_sva (.clk_i, .rst_n_i, .link_clk_i, .link_rst_n_i, .scl_i,
  .sda_i, .sda_o, .scl_o, .sda_oe_o, .scl_oe_o, .reg_ctrl_o, .reg_mask_o, .busy_o,
  .timeout_o);
`default_nettype wire

// ---- cmi2c_sync.sv ----
`default_nettype none
// three-stage pin sampler with condition detection
module cmi2c_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output var cmi2c_pkg::cmi2c_line_t line_o
);
  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
    logic scl_st;
    logic sda_st;
  } cmi2c_sync_st_t;

  cmi2c_sync_st_t s_q;
  cmi2c_sync_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.scl = {s_q.scl[1:0], scl_i};
    s_d.sda = {s_q.sda[1:0], sda_i};
    if (s_q.scl[1] == s_q.scl[2]) begin
      s_d.scl_st = s_q.scl[2];
    end
    if (s_q.sda[1] == s_q.sda[2]) begin
      s_d.sda_st = s_q.sda[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{scl: 3'h7, sda: 3'h7, scl_st: 1'b1, sda_st: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    line_o.scl = s_q.scl_st;
    line_o.sda = s_q.sda_st;
    line_o.scl_fall = s_q.scl_st & ~s_d.scl_st;
    line_o.scl_rise = ~s_q.scl_st & s_d.scl_st;
    line_o.start = s_q.scl_st & s_d.scl_st & s_q.sda_st & ~s_d.sda_st;
    line_o.stop = s_q.scl_st & s_d.scl_st & ~s_q.sda_st & s_d.sda_st;
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
// ==========
// testbench
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic link_rst_n_i = 1'b0;
  logic [7:0] status_i = 8'h00;
  logic [7:0] flag_i = 8'h00;
  logic m_scl, m_sda, sda_oe, scl_oe, sda_d, scl_d, busy_o, timeout_o;
  logic [6:0] wa;
  logic [7:0] exp [10];
  wire logic [63:0] regs_o;
  wire logic scl_w = m_scl & (scl_oe ? scl_d : 1'b1);
  wire logic sda_w = m_sda & (sda_oe ? sda_d : 1'b1);
  int err_count = 0;
  int samples_checked = 0;
  int seed = 17;
  int cyc = 0;
  int tcnt = 0;
  cmi2c_slave #(.TOUT_CYC(200)) DUT (.clk_i, .rst_n_i, .link_clk_i, .link_rst_n_i,
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe), .scl_o(scl_d),
    .scl_oe_o(scl_oe), .status_i, .flag_i, .reg_ctrl_o(regs_o[63:56]),
    .reg_bal_o(regs_o[55:48]), .reg_cur_o(regs_o[47:40]), .reg_sc1_o(regs_o[39:32]),
    .reg_sc2_o(regs_o[31:24]), .reg_scc_o(regs_o[23:16]), .reg_ot_o(regs_o[15:8]),
    .reg_mask_o(regs_o[7:0]), .busy_o, .timeout_o);
  cmi2c_bfm m (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda_w));
  always #20 clk_i = ~clk_i;
  initial begin
    #13;
    forever #62.5 link_clk_i = ~link_clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (timeout_o === 1'b1) tcnt++;
    if (cyc == 60000) begin
      err_count++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [63:0] regs_exp();
    return {exp[0], exp[1], exp[2], exp[3], exp[4], exp[5], exp[6], exp[8]};
  endfunction
  function automatic logic [7:0] rd_exp(input logic [3:0] p);
    return (p >= 4'hA) ? 8'h00 : (p == 4'h7) ? status_i : (p == 4'h9) ? flag_i : exp[p];
  endfunction
  function automatic logic [3:0] nxt(input logic [3:0] p);
    return (p == 4'h9) ? 4'h0 : p + 4'h1;
  endfunction
  task automatic addr(input logic [7:0] b, input logic want);
    logic a;
    m.wr_byte(b, a);
    check("ack", 64'(a), 64'(want));
  endtask
  task automatic wr_regs(input logic [3:0] p, input int n);
    logic [7:0] d;
    @(posedge clk_i);
    #1 m.start();
    addr(8'hBA, 1'b1);
    check("busy", 64'(busy_o), 64'h1);
    addr({4'h0, p}, 1'b1);
    repeat (n) begin
      d = 8'($random(seed));
      addr(d, 1'b1);
      if (p != 4'h7 && p != 4'h9 && p < 4'hA) exp[p] = d;
      p = nxt(p);
    end
    m.stop();
    repeat (40) @(posedge clk_i);
    check("busy", 64'(busy_o), 64'h0);
    check("regs", regs_o, regs_exp());
  endtask
  task automatic rd_regs(input logic [3:0] p, input int n);
    logic [7:0] d;
    @(posedge clk_i);
    #1 status_i = 8'($random(seed));
    flag_i = 8'($random(seed));
    m.start();
    addr(8'hBA, 1'b1);
    addr({4'h0, p}, 1'b1);
    m.start();
    addr(8'hBB, 1'b1);
    for (int i = 1; i <= n; i++) begin
      m.rd_byte(d, i == n);
      check("rdata", 64'(d), 64'(rd_exp(p)));
      p = nxt(p);
    end
    m.stop();
    repeat (40) @(posedge clk_i);
  endtask
  initial begin
    exp = '{8'h80, 8'h00, 8'h00, 8'h81, 8'h01, 8'h03, 8'h92, 8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    repeat (2) @(posedge link_clk_i);
    #1 link_rst_n_i = 1'b1;
    repeat (8) @(posedge link_clk_i);
    check("reset regs", regs_o, regs_exp());
    @(posedge clk_i);
    #1 m.start();
    addr(8'hBA, 1'b1);
    #40000;
    check("timeouts", 64'(tcnt), 64'h1);
    check("busy", 64'(busy_o), 64'h0);
    check("regs", regs_o, regs_exp());
    m.stop();
    for (int i = 0; i < 3; i++) begin
      wa = (i == 0) ? 7'h5C : 7'($random(seed));
      if (wa == 7'h5D) wa = 7'h1D;
      m.start();
      addr({wa, 1'b0}, 1'b0);
      addr(8'h12, 1'b0);
      m.stop();
    end
    wr_regs(4'h8, 3);
    wr_regs(4'h7, 1);
    wr_regs(4'hB, 1);
    repeat (3) wr_regs(4'($unsigned($random(seed)) % 10), 1 + $unsigned($random(seed)) % 3);
    #30000;
    check("timeouts", 64'(tcnt), 64'h1);
    rd_regs(4'h8, 3);
    rd_regs(4'h6, 2);
    rd_regs(4'hC, 1);
    repeat (2) rd_regs(4'($unsigned($random(seed)) % 10), 2);
    conclude();
  end
endmodule
`default_nettype wire
